//--- rtl/sram_pkg.sv
// Function
// - controller strobe low: drop burst, load address, access if all three chip selects active
// - controller strobe with primary select high enters power-down
// - processor strobe low: drop burst, load address, read; byte writes ignored
// - processor strobe is ignored while primary select is high
// - processor strobe with secondary selects negated enters power-down
// - burst counter steps on each edge with advance low
// - advance high holds the burst address as a wait state
// - lane selects count only while the lane write enable is low
// - each lane select gates its own data byte, lane 3 to byte 3
// - chip selects are sampled only on address-load edges
// - positive select active high, the other two active low, all needed
// - all synchronous inputs captured on the rising clock edge only
// - full-word write low writes every byte regardless of lane controls
// - one parity bit per byte; lanes have no function on 32-bit variant
// - burst order pin high: interleaved, low address bits xor step count
// - burst order pin low: linear, low address bits plus step modulo four
// - snooze high: standby, contents kept, memory-side inputs ignored; AXI register port still served
package sram_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int IDX_W = 6;
  localparam int AXI_AW = 12;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [AXI_AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [AXI_AW-1:0] STATUS_OFS = 12'h004;
  localparam logic [AXI_AW-1:0] LOAD_ADDR_OFS = 12'h008;
  localparam int CTRL_PAR_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_DOWN_BIT = 1;
  localparam int ST_SNOOZE_BIT = 2;
  localparam int ST_INTERLEAVE_BIT = 3;
  localparam int ST_STEP_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // port state
  // ****************************************************************
  typedef enum logic [1:0] {
    PORT_IDLE = 2'b00,
    PORT_ACTIVE = 2'b01,
    PORT_DOWN = 2'b10
  } port_state_t;

endpackage

//--- rtl/sram_array.sv
`timescale 1ns/1ps
module sram_array (
  // clock
  input wire logic clk,
  // write side
  input wire logic [sram_pkg::IDX_W-1:0] wr_idx,
  input wire logic [sram_pkg::LANES-1:0] wr_lane,
  input wire logic [sram_pkg::LANES*sram_pkg::LANE_W-1:0] wr_word,
  // read side
  input wire logic [sram_pkg::IDX_W-1:0] rd_idx,
  output logic [sram_pkg::LANES*sram_pkg::LANE_W-1:0] rd_word
);

  // ****************************************************************
  // storage, one flop bank per byte lane
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < sram_pkg::LANES; g++) begin : g_lane
      logic [sram_pkg::LANE_W-1:0] mem_r [2**sram_pkg::IDX_W];
      // no reset: contents survive reset and snooze alike
      always_ff @(posedge clk) begin
        if (wr_lane[g]) begin
          mem_r[wr_idx] <= wr_word[g*sram_pkg::LANE_W +: sram_pkg::LANE_W];
        end
      end
      // combinational read; the port registers it
      assign rd_word[g*sram_pkg::LANE_W +: sram_pkg::LANE_W] = mem_r[rd_idx];
    end
  endgenerate

endmodule

//--- rtl/sync_burst_sram_port.sv
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module sync_burst_sram_port (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [sram_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [sram_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // memory address and strobes
  input wire logic [sram_pkg::ADDR_W-1:0] mem_addr,
  input wire logic ctrl_addr_strobe_n,
  input wire logic proc_addr_strobe_n,
  input wire logic burst_advance_n,
  // chip selects
  input wire logic chip_sel_primary_n,
  input wire logic chip_sel_secondary_n,
  input wire logic chip_sel_positive,
  // write controls
  input wire logic full_word_write_n,
  input wire logic lane_write_enable_n,
  input wire logic lane0_write_sel_n,
  input wire logic lane1_write_sel_n,
  input wire logic lane2_write_sel_n,
  input wire logic lane3_write_sel_n,
  // mode and standby
  input wire logic burst_order_sel,
  input wire logic snooze_req,
  // data lanes, byte n in bits 8n+7..8n
  input wire logic [sram_pkg::DATA_W-1:0] data_in,
  output logic [sram_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  // parity lanes, bit n for byte n
  input wire logic [sram_pkg::LANES-1:0] parity_in,
  output logic [sram_pkg::LANES-1:0] parity_out,
  output logic parity_oe_n
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  sram_pkg::port_state_t state_r;
  sram_pkg::port_state_t state_nxt;
  logic snz_meta_r;
  logic snz_r;
  logic [sram_pkg::ADDR_W-3:0] hi_r;
  logic [1:0] base_r;
  logic [1:0] step_r;
  logic [1:0] step_nxt;
  logic [1:0] base_use;
  logic [1:0] cur_low;
  logic [sram_pkg::ADDR_W-1:0] cur_addr;
  logic [sram_pkg::ADDR_W-1:0] load_addr_r;
  logic proc_take;
  logic ctrl_take;
  logic load;
  logic selected;
  logic cont;
  logic access;
  logic do_write;
  logic [sram_pkg::LANES-1:0] lane_sel_n;
  logic [sram_pkg::LANES-1:0] wr_lanes;
  logic [sram_pkg::LANES*sram_pkg::LANE_W-1:0] wr_word;
  logic [sram_pkg::LANES*sram_pkg::LANE_W-1:0] rd_word;
  logic [sram_pkg::DATA_W-1:0] data_out_r;
  logic [sram_pkg::LANES-1:0] parity_out_r;
  logic rd_valid_r;
  logic [31:0] ctrl_r;
  logic par_en;
  logic aw_held_r;
  logic [sram_pkg::AXI_AW-1:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [1:0] rd_resp_mux;

  // ****************************************************************
  // snooze synchroniser
  // ****************************************************************
  // snooze is asynchronous, so it passes two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snz_meta_r <= 1'b0;
      snz_r <= 1'b0;
    end else begin
      snz_meta_r <= snooze_req;
      snz_r <= snz_meta_r;
    end
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  assign lane_sel_n = {lane3_write_sel_n, lane2_write_sel_n,
                       lane1_write_sel_n, lane0_write_sel_n};
  assign par_en = ctrl_r[sram_pkg::CTRL_PAR_EN_BIT];

  // strobes and selects are looked at on load edges only
  always_comb begin
    proc_take = !proc_addr_strobe_n && !chip_sel_primary_n;
    ctrl_take = !ctrl_addr_strobe_n && !proc_take;
    load = proc_take || ctrl_take;
    selected = !chip_sel_primary_n && chip_sel_positive
               && !chip_sel_secondary_n;
  end

  // write lane decode; full-word write overrides the lane controls
  always_comb begin
    if (!full_word_write_n) begin
      wr_lanes = '1;
    end else if (!lane_write_enable_n) begin
      wr_lanes = ~lane_sel_n;
    end else begin
      wr_lanes = '0;
    end
  end

  // ****************************************************************
  // burst address
  // ****************************************************************
  // step is applied before the access, so a held advance repeats the
  // current location; that is why a write right after a processor
  // load needs advance high
  always_comb begin
    if (load) begin
      step_nxt = 2'h0;
      base_use = mem_addr[1:0];
    end else if (!burst_advance_n) begin
      step_nxt = step_r + 2'h1;
      base_use = base_r;
    end else begin
      step_nxt = step_r;
      base_use = base_r;
    end
    if (burst_order_sel) begin
      cur_low = base_use ^ step_nxt;
    end else begin
      cur_low = base_use + step_nxt;
    end
    cur_addr = {(load ? mem_addr[sram_pkg::ADDR_W-1:2] : hi_r), cur_low};
  end

  // ****************************************************************
  // access qualification
  // ****************************************************************
  always_comb begin
    cont = (state_r == sram_pkg::PORT_ACTIVE) && !load;
    access = !snz_r && ((load && selected) || cont);
    // processor loads are reads whatever the lane controls say
    do_write = access && !proc_take && (wr_lanes != '0);
  end

  // ****************************************************************
  // port state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    if (!snz_r && load) begin
      if (selected) begin
        state_nxt = sram_pkg::PORT_ACTIVE;
      end else begin
        state_nxt = sram_pkg::PORT_DOWN;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= sram_pkg::PORT_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // burst registers; only on real accesses, frozen in snooze
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_r <= '0;
      base_r <= 2'h0;
      step_r <= 2'h0;
      load_addr_r <= '0;
    end else if (access) begin
      if (load) begin
        hi_r <= mem_addr[sram_pkg::ADDR_W-1:2];
        base_r <= mem_addr[1:0];
        load_addr_r <= mem_addr;
      end
      step_r <= step_nxt;
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < sram_pkg::LANES; g++) begin : g_pack
      // parity lanes carry no function when parity is off
      assign wr_word[g*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
        {(par_en & parity_in[g]), data_in[g*8 +: 8]};
    end
  endgenerate

  sram_array u_array (
    .clk(aclk),
    .wr_idx(cur_addr[sram_pkg::IDX_W-1:0]),
    .wr_lane(do_write ? wr_lanes : {sram_pkg::LANES{1'b0}}),
    .wr_word(wr_word),
    .rd_idx(cur_addr[sram_pkg::IDX_W-1:0]),
    .rd_word(rd_word)
  );

  // ****************************************************************
  // read data register
  // ****************************************************************
  // one clock from capture to data, same for each beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out_r <= '0;
      parity_out_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= access && !do_write;
      if (access && !do_write) begin
        for (int i = 0; i < sram_pkg::LANES; i++) begin
          data_out_r[i*8 +: 8] <= rd_word[i*sram_pkg::LANE_W +: 8];
          parity_out_r[i] <= rd_word[i*sram_pkg::LANE_W + 8] & par_en;
        end
      end
    end
  end

  assign data_out = data_out_r;
  assign parity_out = parity_out_r;
  assign data_oe_n = !rd_valid_r;
  assign parity_oe_n = !(rd_valid_r && par_en);

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  // address and data are held separately, so either may come first
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= sram_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (aw_held_r && w_held_r && !bvalid_r) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        if (aw_addr_r[sram_pkg::AXI_AW-1:2] == sram_pkg::CTRL_OFS[sram_pkg::AXI_AW-1:2]) begin
          bresp_r <= sram_pkg::RESP_OKAY;
        end else if (aw_addr_r[sram_pkg::AXI_AW-1:2]
                     == sram_pkg::STATUS_OFS[sram_pkg::AXI_AW-1:2]) begin
          bresp_r <= sram_pkg::RESP_OKAY;
        end else if (aw_addr_r[sram_pkg::AXI_AW-1:2]
                     == sram_pkg::LOAD_ADDR_OFS[sram_pkg::AXI_AW-1:2]) begin
          bresp_r <= sram_pkg::RESP_OKAY;
        end else begin
          bresp_r <= sram_pkg::RESP_SLVERR;
        end
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // control register; only byte 0 holds a field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= sram_pkg::CTRL_RST;
    end else if (aw_held_r && w_held_r && !bvalid_r && w_strb_r[0]
                 && aw_addr_r[sram_pkg::AXI_AW-1:2]
                    == sram_pkg::CTRL_OFS[sram_pkg::AXI_AW-1:2]) begin
      ctrl_r[sram_pkg::CTRL_PAR_EN_BIT] <= w_data_r[sram_pkg::CTRL_PAR_EN_BIT];
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  always_comb begin
    status_word = '0;
    status_word[sram_pkg::ST_ACTIVE_BIT] = (state_r == sram_pkg::PORT_ACTIVE);
    status_word[sram_pkg::ST_DOWN_BIT] = (state_r == sram_pkg::PORT_DOWN);
    status_word[sram_pkg::ST_SNOOZE_BIT] = snz_r;
    status_word[sram_pkg::ST_INTERLEAVE_BIT] = burst_order_sel;
    status_word[sram_pkg::ST_STEP_LSB +: 2] = step_r;
    rd_resp_mux = sram_pkg::RESP_OKAY;
    if (araddr[sram_pkg::AXI_AW-1:2] == sram_pkg::CTRL_OFS[sram_pkg::AXI_AW-1:2]) begin
      rd_mux = ctrl_r;
    end else if (araddr[sram_pkg::AXI_AW-1:2]
                 == sram_pkg::STATUS_OFS[sram_pkg::AXI_AW-1:2]) begin
      rd_mux = status_word;
    end else if (araddr[sram_pkg::AXI_AW-1:2]
                 == sram_pkg::LOAD_ADDR_OFS[sram_pkg::AXI_AW-1:2]) begin
      rd_mux = {{(32 - sram_pkg::ADDR_W){1'b0}}, load_addr_r};
    end else begin
      rd_mux = '0;
      rd_resp_mux = sram_pkg::RESP_SLVERR;
    end
  end

  // one read at a time; a new address waits for the data to drain
  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= sram_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_resp_mux;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

//--- test/mem_ctl_model.sv
`timescale 1ns/1ps
module mem_ctl_model (
  // clock
  input wire logic aclk,
  // memory controls
  output logic [sram_pkg::ADDR_W-1:0] mem_addr,
  output logic ctrl_addr_strobe_n,
  output logic proc_addr_strobe_n,
  output logic burst_advance_n,
  output logic chip_sel_primary_n,
  output logic chip_sel_secondary_n,
  output logic chip_sel_positive,
  output logic full_word_write_n,
  output logic lane_write_enable_n,
  output logic [3:0] lane_sel_n,
  // write data
  output logic [sram_pkg::DATA_W-1:0] data_in,
  output logic [3:0] parity_in
);
  logic last_ps = 1'b0;
  // idle bus at time zero
  initial begin
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'b111;
    {chip_sel_primary_n, chip_sel_secondary_n, chip_sel_positive} = 3'b110;
    {full_word_write_n, lane_write_enable_n, lane_sel_n} = 6'h3F;
    mem_addr = '0;
    {parity_in, data_in} = '0;
  end
  // one cycle; sn = {proc, ctrl}, sel = {primary_n, secondary_n, positive}
  task automatic cyc(input logic [1:0] sn, input logic adv_n, input logic [2:0] sel,
                     input logic [5:0] wr, input logic [18:0] a, input logic [35:0] d);
    @(posedge aclk);
    {proc_addr_strobe_n, ctrl_addr_strobe_n} <= sn;
    // a write after a processor load keeps the loaded address
    burst_advance_n <= (last_ps && wr[5:4] != 2'b11) ? 1'b1 : adv_n;
    {chip_sel_primary_n, chip_sel_secondary_n, chip_sel_positive} <= sel;
    {full_word_write_n, lane_write_enable_n, lane_sel_n} <= wr;
    mem_addr <= a;
    // idle data lines toggle so stale data never looks valid
    {parity_in, data_in} <= (wr[5:4] == 2'b11) ? ~{parity_in, data_in} : d;
    last_ps = !sn[1] && !sel[2];
  endtask
endmodule

//--- test/sync_burst_sram_port_assertions.sv
`timescale 1ns/1ps
module sync_burst_sram_port_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // memory controls
  input wire logic ctrl_addr_strobe_n,
  input wire logic proc_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic chip_sel_primary_n,
  input wire logic chip_sel_secondary_n,
  input wire logic chip_sel_positive,
  input wire logic full_word_write_n,
  input wire logic lane_write_enable_n,
  input wire logic lane0_write_sel_n,
  input wire logic snooze_req,
  // memory outputs
  input wire logic [sram_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe_n,
  input wire logic parity_oe_n
);
  logic [3:0] zz_hist_r;
  // snooze history: the synchroniser lag can still gate accesses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zz_hist_r <= 4'hF;
    end else begin
      zz_hist_r <= {zz_hist_r[2:0], snooze_req};
    end
  end
  // decoded load conditions
  wire calm = (zz_hist_r == 4'h0) && !snooze_req;
  wire sel_all = !chip_sel_primary_n && !chip_sel_secondary_n && chip_sel_positive;
  wire no_wr = full_word_write_n && lane_write_enable_n;
  wire proc_ld = !proc_addr_strobe_n && !chip_sel_primary_n;
  wire ctrl_ld = !ctrl_addr_strobe_n && !proc_ld;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_read_load;
    calm && ctrl_ld && sel_all && no_wr |=> !data_oe_n;
  endproperty
  a_read_load: assert property (p_read_load) else $error("read load not driven");
  property p_ctrl_down;
    !ctrl_addr_strobe_n && chip_sel_primary_n |=> data_oe_n;
  endproperty
  a_ctrl_down: assert property (p_ctrl_down) else $error("deselected load drove");
  property p_proc_read;
    calm && proc_ld && sel_all |=> !data_oe_n;
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("processor load not read");
  property p_proc_down;
    proc_ld && !sel_all |=> data_oe_n;
  endproperty
  a_proc_down: assert property (p_proc_down) else $error("processor load drove");
  property p_full_write;
    calm && ctrl_ld && sel_all && !full_word_write_n |=> data_oe_n;
  endproperty
  a_full_write: assert property (p_full_write) else $error("full write drove");
  property p_lane_write;
    calm && ctrl_ld && sel_all && !lane_write_enable_n && !lane0_write_sel_n |=> data_oe_n;
  endproperty
  a_lane_write: assert property (p_lane_write) else $error("lane write drove");
  property p_wait_hold;
    calm && ctrl_ld && sel_all && no_wr ##1 calm && ctrl_addr_strobe_n && proc_addr_strobe_n
      && burst_advance_n && no_wr && chip_sel_primary_n |=> !data_oe_n && $stable(data_out);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait state moved");
  property p_snooze;
    snooze_req [*5] |-> data_oe_n;
  endproperty
  a_snooze: assert property (p_snooze) else $error("access during snooze");
  property p_parity_lane;
    !parity_oe_n |-> !data_oe_n;
  endproperty
  a_parity_lane: assert property (p_parity_lane) else $error("parity drove alone");
endmodule
bind sync_burst_sram_port sync_burst_sram_port_assertions chk_u (.aclk, .aresetn,
  .ctrl_addr_strobe_n, .proc_addr_strobe_n, .burst_advance_n, .chip_sel_primary_n,
  .chip_sel_secondary_n, .chip_sel_positive, .full_word_write_n, .lane_write_enable_n,
  .lane0_write_sel_n, .snooze_req, .data_out, .data_oe_n, .parity_oe_n);

//--- test/sync_burst_sram_port_tb.sv
`timescale 1ns/1ps
module sync_burst_sram_port_tb;
  // ****************
  // signals and model state
  // ****************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, data_oe_n, parity_oe_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, data_out, data_in;
  logic [3:0] parity_out, parity_in, lane_sel_n;
  logic [18:0] mem_addr;
  logic ctrl_addr_strobe_n, proc_addr_strobe_n, burst_advance_n, chip_sel_primary_n;
  logic chip_sel_secondary_n, chip_sel_positive, full_word_write_n, lane_write_enable_n;
  logic burst_order_sel = 1'b0, snooze_req = 1'b0;
  logic [31:0] mem_d [64];
  logic [3:0] mem_p [64];
  int n_fail = 0, num_checks = 0, cycles = 0, seed = 32'h7D548689;
  logic act_m = 1'b0, zz_m = 1'b0, par_m = 1'b1, chk_on = 1'b0, exp_oe = 1'b1;
  logic [18:0] base_m;
  logic [1:0] step_m;
  logic [35:0] exp_q;
  // clock and hang limit
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end
  sync_burst_sram_port dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .mem_addr, .ctrl_addr_strobe_n, .proc_addr_strobe_n, .burst_advance_n,
    .chip_sel_primary_n, .chip_sel_secondary_n, .chip_sel_positive, .full_word_write_n,
    .lane_write_enable_n, .lane0_write_sel_n(lane_sel_n[0]), .lane1_write_sel_n(lane_sel_n[1]),
    .lane2_write_sel_n(lane_sel_n[2]), .lane3_write_sel_n(lane_sel_n[3]), .burst_order_sel,
    .snooze_req, .data_in, .data_out, .data_oe_n, .parity_in, .parity_out, .parity_oe_n);
  mem_ctl_model ctl_u (.aclk, .mem_addr, .ctrl_addr_strobe_n, .proc_addr_strobe_n,
    .burst_advance_n, .chip_sel_primary_n, .chip_sel_secondary_n, .chip_sel_positive,
    .full_word_write_n, .lane_write_enable_n, .lane_sel_n, .data_in, .parity_in);
  // ****************
  // tasks
  // ****************
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  // checks the last capture, then models this one
  task automatic mc(input logic [1:0] sn, input logic a_n, input logic [2:0] sel,
                    input logic [5:0] wr, input logic [18:0] a, input logic [35:0] d);
    logic [3:0] m;
    logic [5:0] ix;
    ctl_u.cyc(sn, a_n, sel, wr, a, d);
    @(negedge aclk);
    if (chk_on) begin
      check("data_oe_n", 36'(data_oe_n), 36'(exp_oe));
      check("parity_oe_n", 36'(parity_oe_n), 36'(exp_oe | !par_m));
      if (!exp_oe) check("data_out", {parity_out, data_out}, exp_q);
    end
    chk_on = 1'b1;
    m = !wr[5] ? 4'hF : !wr[4] ? ~wr[3:0] : 4'h0;
    exp_oe = 1'b1;
    if (zz_m) begin
      m = 4'h0;
    end else if (!sn[1] && !sel[2]) begin
      base_m = a;
      step_m = 2'd0;
      act_m = !sel[1] && sel[0];
      m = 4'h0;
    end else if (!sn[0]) begin
      base_m = a;
      step_m = 2'd0;
      act_m = (sel == 3'b001);
    end else begin
      step_m = step_m + {1'b0, !a_n};
    end
    if (act_m && !zz_m) begin
      ix = {base_m[5:2], burst_order_sel ? (base_m[1:0] ^ step_m) : (base_m[1:0] + step_m)};
      for (int i = 0; i < 4; i++) begin
        if (m[i]) mem_d[ix][8*i+:8] = d[8*i+:8];
        if (m[i] && par_m) mem_p[ix][i] = d[32+i];
      end
      exp_oe = (m != 4'h0);
      exp_q = {mem_p[ix] & {4{par_m}}, mem_d[ix]};
    end
  endtask
  task automatic desel();
    mc(2'b10, 1'b1, 3'b100, 6'h3F, 19'h0, 36'h0);
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ka, kw, kb;
    logic [1:0] rs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ka = awvalid && awready;
      kw = wvalid && wready;
      kb = bvalid;
      rs = bresp;
      @(posedge aclk);
      awvalid <= awvalid && !ka;
      wvalid <= wvalid && !kw;
      bready <= !kb;
    end while (!kb);
    check("bresp", 36'(rs), 36'(er));
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ka, kd;
    logic [33:0] rv;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ka = arvalid && arready;
      kd = rvalid;
      rv = {rresp, rdata};
      @(posedge aclk);
      arvalid <= arvalid && !ka;
      rready <= !kd;
    end while (!kd);
    check("read", 36'(rv), 36'({er, ed}));
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [18:0] a;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(sram_pkg::CTRL_OFS, sram_pkg::CTRL_RST, sram_pkg::RESP_OKAY);
    axi_rd(12'h00C, 32'h0, sram_pkg::RESP_SLVERR);
    axi_wr(12'h010, 32'hFFFF_FFFF, sram_pkg::RESP_SLVERR);
    axi_wr(sram_pkg::STATUS_OFS, 32'hFFFF_FFFF, sram_pkg::RESP_OKAY);
    axi_rd(sram_pkg::STATUS_OFS, 32'h0, sram_pkg::RESP_OKAY);
    // full-word fill of every word, then lane writes read back
    for (int i = 0; i < 64; i++) begin
      a = 19'($random(seed));
      a[5:0] = 6'(i);
      mc(2'b10, 1'b1, 3'b001, 6'h1F, a, 36'({$random(seed), $random(seed)}));
    end
    for (int i = 0; i < 18; i++) begin
      a = 19'($random(seed));
      mc(2'b10, 1'b1, 3'b001, 6'(i + 32), a, 36'({$random(seed), $random(seed)}));
      mc(2'b10, 1'b1, 3'b001, 6'h3F, a, 36'h0);
    end
    // bursts in both orders, order changed only under reset
    for (int o = 0; o < 2; o++) begin
      desel();
      @(posedge aclk);
      aresetn <= 1'b0;
      burst_order_sel <= o[0];
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int b = 0; b < 4; b++) begin
        a = 19'($random(seed));
        a[1:0] = 2'(b);
        mc(2'b10, 1'b1, 3'b001, 6'h3F, a, 36'h0);
        mc(2'b11, 1'b1, 3'b100, 6'h3F, ~a, 36'h0);
        mc(2'b01, 1'b0, 3'b100, 6'h3F, ~a, 36'h0);
        repeat (3) mc(2'b11, 1'b0, 3'b000, 6'h3F, ~a, 36'h0);
      end
      mc(2'b11, 1'b1, 3'b000, 6'h3F, ~a, 36'h0);
      axi_rd(sram_pkg::LOAD_ADDR_OFS, {13'h0, a}, sram_pkg::RESP_OKAY);
    end
    // processor load, write after it, and every select pattern
    a = 19'($random(seed));
    mc(2'b01, 1'b1, 3'b001, 6'h1F, a, 36'h0);
    mc(2'b11, 1'b1, 3'b001, 6'h20, a, 36'h5_A5A5_5A5A);
    mc(2'b11, 1'b1, 3'b001, 6'h3F, a, 36'h0);
    for (int s = 0; s < 4; s++) mc(2'b01, 1'b1, 3'(s), 6'h1F, a, 36'h0);
    for (int s = 0; s < 8; s++) mc(2'b10, 1'b1, 3'(s), 6'h3F, a, 36'h0);
    mc(2'b11, 1'b0, 3'b001, 6'h3F, a, 36'h0);
    // parity lanes off in the 32-bit variant
    axi_wr(sram_pkg::CTRL_OFS, 32'h0, sram_pkg::RESP_OKAY);
    par_m = 1'b0;
    mc(2'b10, 1'b1, 3'b001, 6'h3F, a, 36'h0);
    desel();
    axi_wr(sram_pkg::CTRL_OFS, 32'h1, sram_pkg::RESP_OKAY);
    par_m = 1'b1;
    // snooze: loads ignored, contents kept
    @(posedge aclk);
    snooze_req <= 1'b1;
    repeat (4) desel();
    zz_m = 1'b1;
    mc(2'b10, 1'b1, 3'b001, 6'h1F, a, 36'hF_FFFF_FFFF);
    mc(2'b10, 1'b1, 3'b001, 6'h3F, a, 36'h0);
    desel();
    @(posedge aclk);
    snooze_req <= 1'b0;
    repeat (4) desel();
    zz_m = 1'b0;
    mc(2'b10, 1'b1, 3'b001, 6'h3F, a, 36'h0);
    desel();
    close_out();
  end
endmodule
